/* rtl/frs_pkg.sv */
// Package of timing constants and carrier types for the flash reset sequencer
package frs_pkg;

    // ************************************************************
    // Clock
    // ************************************************************
    localparam int unsigned CLK_PERIOD_NS = 100;

    // ************************************************************
    // Timing figures in their own units
    // ************************************************************
    localparam int unsigned LEG_PULSE_US = 35;
    localparam int unsigned NEW_PULSE_NS = 200;
    localparam int unsigned ASSERT_TO_SEL_US = 35;
    localparam int unsigned LEG_REL_TO_SEL_NS = 200;
    localparam int unsigned NEW_REL_TO_SEL_NS = 50;
    localparam int unsigned LEG_SUPPLY_US = 35;
    localparam int unsigned NEW_SUPPLY_US = 300;
    localparam int unsigned DESEL_MIN_NS = 20;

    // ************************************************************
    // Cycle counts, rounded up, at least one
    // ************************************************************
    function automatic int unsigned frs_cyc(input int unsigned ns);
        int unsigned c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : frs_cyc

    localparam int unsigned LEG_PULSE_CYC = frs_cyc(LEG_PULSE_US * 1000);
    localparam int unsigned NEW_PULSE_CYC = frs_cyc(NEW_PULSE_NS);
    localparam int unsigned ASSERT_TO_SEL_CYC =
        frs_cyc(ASSERT_TO_SEL_US * 1000);
    localparam int unsigned LEG_REL_CYC = frs_cyc(LEG_REL_TO_SEL_NS);
    localparam int unsigned NEW_REL_CYC = frs_cyc(NEW_REL_TO_SEL_NS);
    localparam int unsigned LEG_SUPPLY_CYC = frs_cyc(LEG_SUPPLY_US * 1000);
    localparam int unsigned NEW_SUPPLY_CYC = frs_cyc(NEW_SUPPLY_US * 1000);
    localparam int unsigned DESEL_CYC = frs_cyc(DESEL_MIN_NS);

    localparam int unsigned CNT_W = 16;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        FRS_SUPPLY = 3'b000,
        FRS_PULSE = 3'b001,
        FRS_RELEASE = 3'b010,
        FRS_DESELECT = 3'b011,
        FRS_READY = 3'b100
    } frs_state_e;

    // Pins toward the flash
    typedef struct packed {
        logic init_n;
        logic select_n;
    } frs_pins_s;

    // Sequencer state, without the select flop, synchronisers and run counters
    typedef struct packed {
        frs_state_e state;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] since_assert;
        logic init_n;
        logic ready;
    } frs_state_s;

endpackage : frs_pkg

/* rtl/frs_sequencer.sv */
// Host-side sequencer for flash reset line and first select edge
`timescale 1ns/1ns
`default_nettype none

// Operation
// [R1] The reset line is held low 35 us (legacy) or 200 ns (newer) per reset.
// [R2] Select stays high until 35 us after the reset line fell.
// [R3] Select stays high 200 ns (legacy) or 50 ns (newer) after reset rises.
// [R4] On the newer part, pulse plus release wait falls short of assert-to-select.
// [R5] First access waits 35 us (legacy) or 300 us (newer) after supplies.
// [R6] On the newer part select is high 20 ns before the first falling edge.
// [R7] The flash ignores select during reset; only a new falling edge counts.
// [R8] Select is actively driven high after every reset, never tied low.
// [R9] Every interval is counted in whole clock cycles, rounded up.
module frs_sequencer
    import frs_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Control
    input wire logic newer_variant_i,
    input wire logic supply_good_i,
    input wire logic warm_reset_i,
    input wire logic user_select_i,
    // Flash pins
    output frs_pkg::frs_pins_s pins_o,
    // Status
    output logic ready_o
);
    import frs_pkg::*;

    // ************************************************************
    // Reset release and input synchronisers
    // ************************************************************
    logic [1:0] rst_sync;
    logic rst_n;
    logic [2:0] good_sync;
    logic [2:0] warm_sync;
    logic good_q;
    logic warm_q;

    // Two-stage release of the asynchronous reset
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rst_sync <= 2'h0;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    // Pin inputs: three stages, change taken when stages 2 and 3 agree
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            good_sync <= 3'h0;
            warm_sync <= 3'h0;
            good_q <= 1'b0;
            warm_q <= 1'b0;
        end
        else
        begin
            good_sync <= {good_sync[1:0], supply_good_i};
            warm_sync <= {warm_sync[1:0], warm_reset_i};
            if (good_sync[1] == good_sync[2])
                good_q <= good_sync[2];
            if (warm_sync[1] == warm_sync[2])
                warm_q <= warm_sync[2];
        end
    end

    // ************************************************************
    // Variant-dependent cycle counts
    // ************************************************************
    logic [CNT_W-1:0] pulse_cyc;
    logic [CNT_W-1:0] rel_cyc;
    logic [CNT_W-1:0] supply_cyc;

    // Counts are minimums; exceeding them is always safe
    assign pulse_cyc = newer_variant_i ? CNT_W'(NEW_PULSE_CYC)
                                       : CNT_W'(LEG_PULSE_CYC); // R1 R9
    assign rel_cyc = newer_variant_i ? CNT_W'(NEW_REL_CYC)
                                     : CNT_W'(LEG_REL_CYC); // R3 R9
    assign supply_cyc = newer_variant_i ? CNT_W'(NEW_SUPPLY_CYC)
                                        : CNT_W'(LEG_SUPPLY_CYC); // R5 R9

    // ************************************************************
    // Sequencer state
    // ************************************************************
    frs_state_s cur;
    frs_state_s nxt;

    // Next-state logic
    always_comb
    begin
        nxt = cur;
        if (cur.since_assert != '1)
            nxt.since_assert = cur.since_assert + CNT_W'(1);
        unique case (cur.state)
            FRS_SUPPLY:
            begin
                // Supply wait runs alongside the power-on reset pulse
                nxt.init_n = 1'b0;
                if (!good_q)
                    nxt.cnt = '0;
                else if (cur.cnt != '1)
                    nxt.cnt = cur.cnt + CNT_W'(1); // R5
                // No +1 on the age: a saturated age would wrap to zero
                if (good_q && cur.cnt + CNT_W'(1) >= supply_cyc
                    && cur.since_assert >= pulse_cyc - CNT_W'(1))
                begin
                    nxt.state = FRS_RELEASE; // R1
                    nxt.init_n = 1'b1;
                    nxt.cnt = '0;
                end
            end
            FRS_PULSE:
            begin
                nxt.cnt = cur.cnt + CNT_W'(1);
                if (cur.cnt + CNT_W'(1) >= pulse_cyc && !warm_q)
                begin
                    nxt.state = FRS_RELEASE; // R1
                    nxt.init_n = 1'b1;
                    nxt.cnt = '0;
                end
            end
            FRS_RELEASE:
            begin
                // Stretch the release wait until assert-to-select is met
                nxt.cnt = cur.cnt + CNT_W'(1);
                if (cur.cnt + CNT_W'(1) >= rel_cyc
                    && cur.since_assert >= CNT_W'(ASSERT_TO_SEL_CYC))
                begin
                    nxt.state = FRS_DESELECT; // R2 R3 R4
                    nxt.cnt = '0;
                end
            end
            FRS_DESELECT:
            begin
                // Select already high here; hold it for the minimum time
                nxt.cnt = cur.cnt + CNT_W'(1);
                if (cur.cnt + CNT_W'(1) >= CNT_W'(DESEL_CYC))
                begin
                    nxt.state = FRS_READY; // R6
                    nxt.ready = 1'b1;
                end
            end
            FRS_READY:
            begin
                nxt.ready = 1'b1;
            end
            default:
            begin
                nxt.state = FRS_SUPPLY;
            end
        endcase
        // Supply loss restarts the power-on path
        if (!good_q)
        begin
            nxt.state = FRS_SUPPLY;
            nxt.init_n = 1'b0;
            nxt.ready = 1'b0;
            nxt.cnt = '0; // R5
            if (cur.state != FRS_SUPPLY)
                nxt.since_assert = '0;
        end
        else if (warm_q && cur.state != FRS_SUPPLY
                 && cur.state != FRS_PULSE)
        begin
            nxt.state = FRS_PULSE; // R1
            nxt.init_n = 1'b0;
            nxt.ready = 1'b0;
            nxt.cnt = '0;
            nxt.since_assert = '0;
        end
    end

    // State register
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cur.state <= FRS_SUPPLY;
            cur.cnt <= '0;
            cur.since_assert <= '0;
            cur.init_n <= 1'b0;
            cur.ready <= 1'b0;
        end
        else
            cur <= nxt;
    end

    // ************************************************************
    // Pin drive
    // ************************************************************
    logic sel_n_q;

    // Select is a flop; forced high until ready so each reset gives an edge
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            sel_n_q <= 1'b1;
        else
            sel_n_q <= !(nxt.ready && cur.ready && user_select_i); // R7 R8
    end

    assign pins_o.init_n = cur.init_n;
    assign pins_o.select_n = sel_n_q;
    assign ready_o = cur.ready;

    // ************************************************************
    // Checks
    // ************************************************************
    logic [CNT_W-1:0] high_run;
    logic [CNT_W-1:0] init_high_run;
    logic [CNT_W-1:0] good_run;

    // Run lengths of select high, reset line high and supply good
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            high_run <= '0;
            init_high_run <= '0;
            good_run <= '0;
        end
        else
        begin
            high_run <= sel_n_q ? ((high_run != '1) ? high_run + CNT_W'(1)
                                                    : high_run) : '0;
            init_high_run <= cur.init_n
                ? ((init_high_run != '1) ? init_high_run + CNT_W'(1)
                                         : init_high_run) : '0;
            good_run <= good_q ? ((good_run != '1) ? good_run + CNT_W'(1)
                                                   : good_run) : '0;
        end
    end

    select_in_reset_a: assert property ( // R7
        @(posedge ref_clk_i) disable iff (!rst_n)
        !pins_o.init_n |-> pins_o.select_n)
        else $error("select low while reset line low");
    assert_window_a: assert property ( // R2
        @(posedge ref_clk_i) disable iff (!rst_n)
        $fell(pins_o.select_n) |->
            $past(cur.since_assert) >= CNT_W'(ASSERT_TO_SEL_CYC))
        else $error("select fell too soon after reset assertion");
    release_wait_a: assert property ( // R3
        @(posedge ref_clk_i) disable iff (!rst_n)
        $fell(pins_o.select_n) |-> $past(init_high_run) >= rel_cyc)
        else $error("select fell too soon after reset release");
    deselect_hold_a: assert property ( // R6 R8
        @(posedge ref_clk_i) disable iff (!rst_n)
        $fell(pins_o.select_n) |-> high_run >= CNT_W'(DESEL_CYC)) // Counts last
        else $error("select not high long enough before first edge");
    pulse_width_a: assert property ( // R1
        @(posedge ref_clk_i) disable iff (!rst_n)
        $rose(pins_o.init_n) |-> $past(cur.since_assert)
            >= pulse_cyc - CNT_W'(1))
        else $error("reset pulse too short");
    supply_settle_a: assert property ( // R5
        @(posedge ref_clk_i) disable iff (!rst_n)
        $fell(pins_o.select_n) |-> good_run >= supply_cyc)
        else $error("select fell before supply settle time");
    supply_wait_a: assert property ( // R5
        @(posedge ref_clk_i) disable iff (!rst_n)
        $rose(ready_o) |-> $past(good_q, 1) && ($past(cur.state) ==
            FRS_DESELECT))
        else $error("ready without supply settle path");
    ready_release_a: assert property ( // R6
        @(posedge ref_clk_i) disable iff (!rst_n)
        $rose(cur.state == FRS_DESELECT) |-> ##[1:2] cur.ready
            || cur.state != FRS_DESELECT)
        else $error("deselect phase overran");

    power_seq_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n)
        $rose(ready_o) && !$past(warm_q));
    warm_seq_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n)
        $rose(warm_q) ##[1:1000] $rose(pins_o.init_n));
    first_access_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n)
        $fell(pins_o.select_n));

endmodule : frs_sequencer

`default_nettype wire

/* tb/frs_flash_model.sv */
// Behavioural flash model that times the host's reset and select edges
`timescale 1ns/1ns
`default_nettype none
module frs_flash_model
    import frs_pkg::*;
(
    // Pins and supply
    input wire frs_pkg::frs_pins_s pins_i,
    input wire logic newer_i,
    input wire logic supply_i,
    // Observations
    output var int viol_o,
    output var int access_o
);
    import frs_pkg::*;
    realtime t_fall = 0.0;
    realtime t_rise = 0.0;
    realtime t_desel = 0.0;
    realtime t_sup = 0.0;

    // ************************************************************
    // Edge timing
    // ************************************************************
    initial
    begin
        viol_o = 0;
        access_o = 0;
    end
    always @(posedge supply_i) t_sup = $realtime;
    always @(negedge pins_i.init_n) t_fall = $realtime;
    always @(posedge pins_i.select_n) t_desel = $realtime;
    // Pulse width and deselected release
    always @(posedge pins_i.init_n)
    begin
        if ($realtime - t_fall < (newer_i ? NEW_PULSE_NS
                                          : LEG_PULSE_US * 1000))
            viol_o++;
        if (pins_i.select_n !== 1'h1)
            viol_o++;
        t_rise = $realtime;
    end
    // Select is ignored while the reset line is low
    always @(negedge pins_i.select_n)
    begin
        if (pins_i.init_n === 1'h1)
        begin
            if ($realtime - t_fall < ASSERT_TO_SEL_US * 1000)
                viol_o++;
            if ($realtime - t_rise < (newer_i ? NEW_REL_TO_SEL_NS
                                              : LEG_REL_TO_SEL_NS))
                viol_o++;
            if ($realtime - t_sup < (newer_i ? NEW_SUPPLY_US
                                             : LEG_SUPPLY_US) * 1000)
                viol_o++;
            if (newer_i && $realtime - t_desel < DESEL_MIN_NS)
                viol_o++;
            access_o++;
        end
    end
endmodule : frs_flash_model
`default_nettype wire

/* tb/tb.sv */
// Self-checking testbench for the flash reset sequencer
`timescale 1ns/1ns
`default_nettype none
module tb;
    import frs_pkg::*;
    logic ref_clk_i = 1'h0;
    logic rst_n_i = 1'h0;
    logic newer_variant_i = 1'h0;
    logic supply_good_i = 1'h0;
    logic warm_reset_i = 1'h0;
    logic user_select_i = 1'h1;
    frs_pins_s pins_o;
    logic ready_o;
    int viol, acc, tot, exp_acc = 0, cyc = 0;
    int n_mismatch = 0, n_tests = 0, low_run = 0, last_low = 0;

    // ************************************************************
    // Clock, design, partner, monitors
    // ************************************************************
    always #50 ref_clk_i = ~ref_clk_i;
    frs_sequencer frs_sequencer_i (.ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i), .newer_variant_i(newer_variant_i),
        .supply_good_i(supply_good_i), .warm_reset_i(warm_reset_i),
        .user_select_i(user_select_i), .pins_o(pins_o),
        .ready_o(ready_o));
    frs_flash_model frs_flash_model_i (.pins_i(pins_o),
        .newer_i(newer_variant_i), .supply_i(supply_good_i),
        .viol_o(viol), .access_o(acc));
    // Length of the last reset-line low run, in cycles
    always @(negedge ref_clk_i)
        if (pins_o.init_n === 1'h0)
            low_run <= low_run + 1;
        else if (low_run != 0)
        begin
            last_low <= low_run;
            low_run <= 0;
        end
    // Hang guard, far above the longest sequence
    always @(posedge ref_clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish();
        if (n_mismatch == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish
    // Select must stay high until ready, then fall one cycle later
    task automatic wait_ready();
        tot = 0;
        while (ready_o !== 1'h1 && tot < 5000)
        begin
            @(negedge ref_clk_i);
            tot++;
            check("select_n_held", pins_o.select_n, 1'h1);
        end
        check("ready", ready_o, 1'h1);
        repeat (2) @(negedge ref_clk_i);
        check("select_n_access", pins_o.select_n, 1'h0);
        exp_acc++;
    endtask : wait_ready

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic power_on(input logic newer);
        int sup;
        sup = newer ? NEW_SUPPLY_CYC : LEG_SUPPLY_CYC;
        @(posedge ref_clk_i);
        rst_n_i <= 1'h0;
        supply_good_i <= 1'h0;
        newer_variant_i <= newer;
        repeat (6) @(posedge ref_clk_i);
        rst_n_i <= 1'h1;
        @(negedge ref_clk_i);
        check("pins_in_reset", pins_o, 2'h1);
        repeat (3) @(posedge ref_clk_i);
        supply_good_i <= 1'h1;
        wait_ready();
        check("supply_wait", tot >= sup, 1'h1);
        check("supply_wait_max", tot <= sup + 20, 1'h1);
        check("pulse", last_low >= (newer ? NEW_PULSE_CYC
                                           : LEG_PULSE_CYC), 1'h1);
        // Select follows the request once ready
        @(posedge ref_clk_i) user_select_i <= 1'h0;
        repeat (2) @(negedge ref_clk_i);
        check("select_n_idle", pins_o.select_n, 1'h1);
        @(posedge ref_clk_i) user_select_i <= 1'h1;
        repeat (2) @(negedge ref_clk_i);
        check("select_n_again", pins_o.select_n, 1'h0);
        exp_acc++;
    endtask : power_on
    // Warm reset while the request is held high-active
    task automatic warm(input int hold);
        int pw;
        int tmax;
        pw = newer_variant_i ? NEW_PULSE_CYC : LEG_PULSE_CYC;
        // A long warm request stretches the pulse past assert-to-select
        tmax = (hold > int'(ASSERT_TO_SEL_CYC)) ? hold : ASSERT_TO_SEL_CYC;
        @(posedge ref_clk_i) warm_reset_i <= 1'h1;
        repeat (hold) @(posedge ref_clk_i);
        warm_reset_i <= 1'h0;
        repeat (5) @(negedge ref_clk_i);
        check("ready_drop", ready_o, 1'h0);
        check("select_n_in_warm", pins_o.select_n, 1'h1);
        wait_ready();
        tot = tot + hold + 5;
        check("assert_to_sel", tot >= ASSERT_TO_SEL_CYC, 1'h1);
        check("assert_max", tot <= tmax + 20, 1'h1);
        check("warm_pulse", last_low >= pw, 1'h1);
    endtask : warm
    // Supply loss drops ready and restarts the settle wait
    task automatic supply_loss();
        @(posedge ref_clk_i) supply_good_i <= 1'h0;
        repeat (6) @(negedge ref_clk_i);
        check("ready_loss", ready_o, 1'h0);
        check("select_n_loss", pins_o.select_n, 1'h1);
        @(posedge ref_clk_i) supply_good_i <= 1'h1;
        wait_ready();
        check("resupply_wait", tot >= LEG_SUPPLY_CYC, 1'h1);
    endtask : supply_loss

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        // Warm request must stand two samples to pass the pin filter
        power_on(1'h0);
        warm(2);
        warm(400);
        supply_loss();
        power_on(1'h1);
        warm(2);
        check("host_timing_faults", viol, 0);
        check("accesses", acc, exp_acc);
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
